/* File: rtl/dfp_pkg.sv */
package dfp_pkg;
   // ==========================================
   // reset values and stage layout
   localparam int STAGE_COUNT = 2;
   localparam logic STAGE_RESET = 1'b0;
   localparam logic [1:0] COUNT_RESET = 2'h0;

   typedef struct packed {
      logic true_q;
      logic comp_q;
   } dfp_out_t;

   typedef enum logic [1:0] {
      DFP_IDLE = 2'b01,
      DFP_RUN = 2'b10
   } dfp_state_t;
endpackage

/* File: rtl/dfp_toggle_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module dfp_toggle_stage (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clr_in,
   input wire logic tog_in,
   output logic q_out
);
   logic q_q;
   // ==========================================
   // divide-by-two toggle cell
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_q <= dfp_pkg::STAGE_RESET;
      end else if (clr_in) begin
         q_q <= dfp_pkg::STAGE_RESET;
      end else if (tog_in) begin
         q_q <= ~q_q;
      end
   end
   assign q_out = q_q;
endmodule
`default_nettype wire

/* File: rtl/dfp_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: output period equals four enabled input periods
// R02: two cascaded divide-by-two toggle stages
// R03: true and complement outputs, 50% duty
// R04: enable gates the count input
// R05: reset input clears both stages
// R06: reset honoured only while count or enable high
// R07: after reset true low, complement high
module dfp_prescaler (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic count_in,
   input wire logic enable_in,
   input wire logic clear_in,
   output logic true_out,
   output logic comp_out,
   output dfp_pkg::dfp_out_t pair_out
);
   // ==========================================
   // local signals
   logic count_q;
   logic count_rise;
   logic gated_tick;
   logic clear_ok;
   logic next_hi;
   wire logic [1:0] stage;
   wire logic [1:0] stage_tog;
   wire logic [1:0] stage_nxt;
   dfp_pkg::dfp_state_t state_q;
   dfp_pkg::dfp_state_t state_d;

   // ==========================================
   // input edge detect, count_in sampled on clk_in
   // reset level matches the idle pin level, so no false edge after reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_q <= 1'h0;
      end else begin
         count_q <= count_in;
      end
   end

   // ==========================================
   // qualify edge and clear
   // gating, not async clock muxing: the count input never clocks a flop
   always_comb begin
      count_rise = count_in & ~count_q;
      gated_tick = count_rise & enable_in; // see R04
      // clear only acts while count or enable high
      clear_ok = clear_in & (count_in | enable_in); // see R06
   end

   // ==========================================
   // cascade: a stage toggles when all lower stages fall together
   genvar i;
   generate
      for (i = 0; i < dfp_pkg::STAGE_COUNT; i++) begin : g_stage
         if (i == 0) begin : g_first
            assign stage_tog[i] = gated_tick;
         end else begin : g_next
            assign stage_tog[i] = stage_tog[i-1] & stage[i-1]; // see R02
         end

         // next value, so the registered outputs track the last stage
         assign stage_nxt[i] = clear_ok ? dfp_pkg::STAGE_RESET :
                               (stage_tog[i] ? ~stage[i] : stage[i]);

         dfp_toggle_stage u_stage (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .clr_in(clear_ok), // see R05
            .tog_in(stage_tog[i]),
            .q_out(stage[i])
         );
      end
   endgenerate

   // ==========================================
   // run state: idle from reset or clear until the first counted edge
   always_comb begin
      state_d = state_q;
      case (state_q)
         dfp_pkg::DFP_IDLE: begin
            if (gated_tick && !clear_ok) begin
               state_d = dfp_pkg::DFP_RUN;
            end
         end
         dfp_pkg::DFP_RUN: begin
            if (clear_ok) begin
               state_d = dfp_pkg::DFP_IDLE;
            end
         end
         default: begin
            state_d = dfp_pkg::DFP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= dfp_pkg::DFP_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================
   // output source
   // idle means both stages are known clear, so the output stays low there
   assign next_hi = (state_q == dfp_pkg::DFP_IDLE) ? 1'h0 :
                    stage_nxt[dfp_pkg::STAGE_COUNT-1]; // see R01

   // ==========================================
   // registered outputs, one flop per pin
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         true_out <= 1'h0; // see R07
      end else begin
         true_out <= next_hi; // see R03
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         comp_out <= 1'h1;
      end else begin
         comp_out <= ~next_hi;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pair_out <= '{true_q: 1'h0, comp_q: 1'h1};
      end else begin
         pair_out <= '{true_q: next_hi, comp_q: ~next_hi};
      end
   end
endmodule
`default_nettype wire

/* File: tb/dfp_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ===
// input source standing in for the driving synthesizer
module dfp_src (input wire logic clk_in, input wire logic run_in, output logic count_out);
   // stands low between bursts, like an interrupted input clock
   initial count_out = 1'h0;
   always @(negedge clk_in) count_out <= run_in ? ~count_out : 1'h0;
endmodule
`default_nettype wire

/* File: tb/dfp_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dfp_chk (input wire logic clk_in, rst_in, count_in, enable_in, clear_in, true_out, comp_out);
   // ===
   // shadow of stage zero, cleared like the real one
   logic p_q, s_q;
   wire logic e = count_in & ~p_q & enable_in;
   wire logic k = clear_in & (count_in | enable_in);
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in) {p_q, s_q} <= 2'h0;
      else {p_q, s_q} <= {count_in, ~k & (s_q ^ e)};
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence tick_lo_s; e && !k && !s_q; endsequence
   sequence tick_hi_s; e && !k && s_q; endsequence
   comp_inv_a: assert property (comp_out != true_out) else $error("inv");
   rst_low_a: assert property ($fell(rst_in) |-> !true_out) else $error("rst");
   clr_low_a: assert property (k |=> !true_out) else $error("clr");
   en_gate_a: assert property (!enable_in && !k |=> $stable(true_out)) else $error("en");
   clr_skip_a: assert property (clear_in && !k |=> $stable(true_out)) else $error("skip");
   half_hold_a: assert property (tick_lo_s |=> $stable(true_out)) else $error("half");
   div_flip_a: assert property (tick_hi_s |=> $changed(true_out)) else $error("div");
endmodule
bind dfp_prescaler dfp_chk u_chk (.clk_in, .rst_in, .count_in, .enable_in, .clear_in,
   .true_out, .comp_out);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in = 1'h0, rst_in = 1'h1, run = 1'h0, enable_in = 1'h0, clear_in = 1'h0;
   logic count_in, true_out, comp_out;
   dfp_pkg::dfp_out_t pair_out;
   int num_errors = 0, n_checks = 0;
   // ===
   // rows: enable, clear, pulses, true level
   logic [5:0] rows [10] = '{6'h25, 6'h23, 6'h09, 6'h22, 6'h27,
      6'h30, 6'h25, 6'h11, 6'h12, 6'h25};
   dfp_prescaler DUT (.clk_in, .rst_in, .count_in, .enable_in, .clear_in, .true_out,
      .comp_out, .pair_out);
   dfp_src SRC (.clk_in, .run_in(run), .count_out(count_in));
   task chk(input logic a, b);
      n_checks++;
      num_errors += int'(a !== b);
      if (a !== b) $display("MISMATCH %0t %h %h", $time, a, b);
   endtask
   task chk2(input logic [1:0] a, b);
      n_checks++;
      num_errors += int'(a !== b);
      if (a !== b) $display("MISMATCH %0t %h %h", $time, a, b);
   endtask
   task go(input int n);
      repeat (2 * n) @(negedge clk_in) run <= 1'h1;
      @(negedge clk_in) run <= 1'h0;
   endtask
   task test_done;
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial forever #20 clk_in = ~clk_in;
   // run needs about 3 us
   initial begin #20us; num_errors++; test_done; end
   initial begin
      repeat (10) @(negedge clk_in);
      rst_in <= 1'h0;
      foreach (rows[i]) begin
         {enable_in, clear_in} <= rows[i][5:4];
         go(rows[i][3:1]);
         repeat (2) @(negedge clk_in);
         chk(true_out, rows[i][0]);
         chk(comp_out, !rows[i][0]);
         chk2(pair_out, {rows[i][0], !rows[i][0]});
      end
      rst_in <= 1'h1;
      @(negedge clk_in) rst_in <= 1'h0;
      chk(true_out, 1'h0);
      go(1);
      chk(true_out, 1'h0);
      chk(comp_out, 1'h1);
      chk2(pair_out, 2'h1);
      test_done;
   end
endmodule
`default_nettype wire
